// ==== pkg/cpuam_pkg.sv ====
package cpuam_pkg;

    // ****************************************
    // operand addressing modes
    // ****************************************
    typedef enum logic [2:0] {
        AM_INH,
        AM_IMM,
        AM_DIR,
        AM_EXT,
        AM_IX0,
        AM_IX1,
        AM_IX2,
        AM_REL
    } cpuam_mode_t;

    // ****************************************
    // constants
    // ****************************************
    localparam logic [5:0] NUM_TYPES = 6'h3e;
    localparam logic [1:0] LEN_ONE = 2'h1;
    localparam logic [1:0] LEN_TWO = 2'h2;
    localparam logic [1:0] LEN_THREE = 2'h3;
    localparam logic [7:0] PAGE_ZERO_HI = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [1:0] RST_CNT = 2'h0;

    // ****************************************
    // decode result carrier
    // ****************************************
    typedef struct packed {
        logic [15:0] ea;
        logic [15:0] next_pc;
        logic [7:0] literal;
        logic [1:0] len;
        logic taken;
        logic bad_type;
    } cpuam_res_t;

    localparam cpuam_res_t RST_RES = '{ea: 16'h0000, next_pc: 16'h0000, literal: 8'h00,
                                       len: 2'h0, taken: 1'b0, bad_type: 1'b0};

endpackage

// ==== design/cpuam_unit.sv ====
`timescale 1ns/100ps

// Behaviour
// - 62 instruction types, each decoded into one of eight addressing modes.
// - multiply A by X; high product to X, low product to A.
// - inherent: one byte, no operand address, register-only action.
// - immediate: two bytes, opcode then literal used with A or X.
// - direct: two bytes, address is zero high byte plus operand byte.
// - extended: three bytes, full address high byte first.
// - indexed no offset: one byte, address is zero high byte plus X.
// - indexed 8-bit offset: two bytes, X plus byte, up to 0x01fe.
// - indexed 16-bit offset: three bytes, X plus offset high byte first.
// - relative mode belongs to branch instructions only.
// - taken branch adds sign-extended offset to address after the branch.
// - untaken branch continues with the next instruction.
module cpuam_unit (
    input wire logic i_mclk,
    input wire logic i_rst_b,
    input wire logic i_ce,
    input wire logic i_start,
    input wire logic [5:0] i_type,
    input wire cpuam_pkg::cpuam_mode_t i_mode,
    input wire logic i_is_branch,
    input wire logic i_cond,
    input wire logic [15:0] i_opc_pc,
    input wire logic [7:0] i_idx,
    input wire logic [7:0] i_acc,
    input wire logic i_byte_valid,
    input wire logic [7:0] i_byte,
    input wire logic i_mul,
    output logic o_busy,
    output logic o_need_byte,
    output logic o_done,
    output cpuam_pkg::cpuam_res_t o_res,
    output logic o_mul_done,
    output logic [7:0] o_mul_hi,
    output logic [7:0] o_mul_lo
);

    // ****************************************
    // declarations
    // ****************************************
    typedef enum logic {ST_IDLE, ST_FETCH} cpuam_state_t;

    cpuam_state_t state;
    cpuam_pkg::cpuam_mode_t mode_q;
    logic [1:0] left;
    logic [1:0] got;
    logic [7:0] b1_q;
    logic [7:0] idx_q;
    logic [15:0] pc_q;
    logic cond_q;
    logic bad_q;
    logic take;
    logic start_ok;
    logic [1:0] start_len;
    logic start_bad;
    logic [7:0] fin_b1;
    cpuam_pkg::cpuam_res_t next_res;
    cpuam_pkg::cpuam_res_t start_res;

    function automatic logic [1:0] mode_len(input cpuam_pkg::cpuam_mode_t m);
        case (m)
            cpuam_pkg::AM_INH: mode_len = cpuam_pkg::LEN_ONE;
            cpuam_pkg::AM_IMM: mode_len = cpuam_pkg::LEN_TWO;
            cpuam_pkg::AM_DIR: mode_len = cpuam_pkg::LEN_TWO;
            cpuam_pkg::AM_EXT: mode_len = cpuam_pkg::LEN_THREE;
            cpuam_pkg::AM_IX0: mode_len = cpuam_pkg::LEN_ONE;
            cpuam_pkg::AM_IX1: mode_len = cpuam_pkg::LEN_TWO;
            cpuam_pkg::AM_IX2: mode_len = cpuam_pkg::LEN_THREE;
            cpuam_pkg::AM_REL: mode_len = cpuam_pkg::LEN_TWO;
            default: mode_len = cpuam_pkg::LEN_ONE;
        endcase
    endfunction

    // b1/b2 are the first and second bytes after the opcode
    function automatic cpuam_pkg::cpuam_res_t calc(input cpuam_pkg::cpuam_mode_t m, input logic [7:0] b1,
                                                   input logic [7:0] b2, input logic [7:0] x,
                                                   input logic [15:0] pc, input logic cond, input logic bad);
        cpuam_pkg::cpuam_res_t r;
        logic [15:0] seq;
        logic [15:0] tgt;
        r = cpuam_pkg::RST_RES;
        r.len = mode_len(m);
        r.bad_type = bad;
        seq = pc + {14'h0000, r.len};
        tgt = seq + {{8{b1[7]}}, b1};
        r.next_pc = seq;
        case (m)
            cpuam_pkg::AM_INH: r.ea = cpuam_pkg::RST_WORD;
            cpuam_pkg::AM_IMM: r.literal = b1;
            cpuam_pkg::AM_DIR: r.ea = {cpuam_pkg::PAGE_ZERO_HI, b1};
            cpuam_pkg::AM_EXT: r.ea = {b1, b2};
            cpuam_pkg::AM_IX0: r.ea = {cpuam_pkg::PAGE_ZERO_HI, x};
            cpuam_pkg::AM_IX1: r.ea = {8'h00, x} + {8'h00, b1};
            cpuam_pkg::AM_IX2: r.ea = {b1, b2} + {8'h00, x};
            cpuam_pkg::AM_REL: begin
                // relative only resolves when the decoder marks a branch
                r.taken = cond & ~bad;
                r.ea = tgt;
                r.next_pc = r.taken ? tgt : seq;
            end
            default: r.ea = cpuam_pkg::RST_WORD;
        endcase
        calc = r;
    endfunction

    // ****************************************
    // decode and operand byte collection
    // ****************************************
    always_comb begin
        start_ok = i_start & (state == ST_IDLE);
        start_len = mode_len(i_mode);
        // types past the last one, or relative mode and the branch mark disagreeing, are flagged
        start_bad = (i_type >= cpuam_pkg::NUM_TYPES) | ((i_mode == cpuam_pkg::AM_REL) != i_is_branch);
        take = (state == ST_FETCH) & i_byte_valid;
        fin_b1 = (got == cpuam_pkg::RST_CNT) ? i_byte : b1_q;
        start_res = calc(i_mode, i_byte, i_byte, i_idx, i_opc_pc, i_cond, start_bad);
        next_res = calc(mode_q, fin_b1, i_byte, idx_q, pc_q, cond_q, bad_q);
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state <= ST_IDLE;
            o_busy <= 1'b0;
            o_need_byte <= 1'b0;
            left <= cpuam_pkg::RST_CNT;
            got <= cpuam_pkg::RST_CNT;
        end else if (i_ce) begin
            case (state)
                ST_IDLE: begin
                    if (start_ok && start_len != cpuam_pkg::LEN_ONE) begin
                        state <= ST_FETCH;
                        o_busy <= 1'b1;
                        o_need_byte <= 1'b1;
                        left <= start_len - 2'h1;
                        got <= cpuam_pkg::RST_CNT;
                    end
                end
                ST_FETCH: begin
                    if (take) begin
                        got <= got + 2'h1;
                        left <= left - 2'h1;
                        if (left == 2'h1) begin
                            state <= ST_IDLE;
                            o_busy <= 1'b0;
                            o_need_byte <= 1'b0;
                        end
                    end
                end
                default: begin
                    state <= ST_IDLE;
                    o_busy <= 1'b0;
                    o_need_byte <= 1'b0;
                end
            endcase
        end
    end

    // context of the instruction in flight, held so the caller may move on
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            mode_q <= cpuam_pkg::AM_INH;
            idx_q <= cpuam_pkg::RST_BYTE;
            pc_q <= cpuam_pkg::RST_WORD;
            cond_q <= 1'b0;
            bad_q <= 1'b0;
            b1_q <= cpuam_pkg::RST_BYTE;
        end else if (i_ce) begin
            if (start_ok) begin
                mode_q <= i_mode;
                idx_q <= i_idx;
                pc_q <= i_opc_pc;
                cond_q <= i_cond;
                bad_q <= start_bad;
            end
            if (take && got == cpuam_pkg::RST_CNT) begin
                b1_q <= i_byte;
            end
        end
    end

    // ****************************************
    // result
    // ****************************************
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_done <= 1'b0;
            o_res <= cpuam_pkg::RST_RES;
        end else if (i_ce) begin
            o_done <= 1'b0;
            if (start_ok && start_len == cpuam_pkg::LEN_ONE) begin
                o_done <= 1'b1;
                o_res <= start_res;
            end else if (take && left == 2'h1) begin
                o_done <= 1'b1;
                o_res <= next_res;
            end
        end
    end

    // ****************************************
    // unsigned multiply
    // ****************************************
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_mul_done <= 1'b0;
            o_mul_hi <= cpuam_pkg::RST_BYTE;
            o_mul_lo <= cpuam_pkg::RST_BYTE;
        end else if (i_ce) begin
            o_mul_done <= i_mul;
            if (i_mul) begin
                {o_mul_hi, o_mul_lo} <= {8'h00, i_acc} * {8'h00, i_idx};
            end
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    logic [1:0] seen;
    logic [7:0] first_b;
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            seen <= cpuam_pkg::RST_CNT;
            first_b <= cpuam_pkg::RST_BYTE;
        end else if (i_ce) begin
            if (start_ok) begin
                seen <= cpuam_pkg::RST_CNT;
            end else if (take) begin
                seen <= seen + 2'h1;
                if (seen == cpuam_pkg::RST_CNT) begin
                    first_b <= i_byte;
                end
            end
        end
    end

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_b);

    type_flag_a: assert property (
        start_ok && i_ce && i_type >= 6'h3e |=> bad_q && (o_done || o_busy))
        else $error("bad type lost");
    mul_split_a: assert property (
        i_mul && i_ce |=> o_mul_done && o_mul_hi == 8'(({8'h00, $past(i_acc)} * {8'h00, $past(i_idx)}) >> 8)
        && o_mul_lo == 8'($past(i_acc) * $past(i_idx)))
        else $error("multiply split wrong");
    mul_hold_a: assert property (
        !i_mul && i_ce |=> !o_mul_done && $stable(o_mul_hi) && $stable(o_mul_lo))
        else $error("product not held");
    inh_one_a: assert property (
        start_ok && i_ce && i_mode == cpuam_pkg::AM_INH |=> o_done && o_res.len == 2'h1 && !o_need_byte)
        else $error("inherent not one byte");
    inh_next_a: assert property (
        start_ok && i_ce && i_mode == cpuam_pkg::AM_INH |=> o_res.next_pc == $past(i_opc_pc) + 16'h0001)
        else $error("inherent next address wrong");
    len_count_a: assert property (
        o_done && $past(o_busy) |-> 2'(seen + 2'h1) == o_res.len)
        else $error("byte count mismatch");
    start_busy_a: assert property (
        start_ok && i_ce && i_mode != cpuam_pkg::AM_INH && i_mode != cpuam_pkg::AM_IX0
        |=> o_busy && o_need_byte && !o_done)
        else $error("operand fetch not started");
    imm_lit_a: assert property (
        o_done && mode_q == cpuam_pkg::AM_IMM && $past(o_busy) |-> o_res.literal == first_b && o_res.len == 2'h2)
        else $error("immediate literal wrong");
    dir_page_a: assert property (
        o_done && mode_q == cpuam_pkg::AM_DIR && $past(o_busy) |-> o_res.ea == {8'h00, first_b})
        else $error("direct address wrong");
    ext_order_a: assert property (
        o_done && mode_q == cpuam_pkg::AM_EXT && $past(o_busy) |-> o_res.ea[15:8] == first_b && o_res.len == 2'h3)
        else $error("extended order wrong");
    ix0_page_a: assert property (
        start_ok && i_ce && i_mode == cpuam_pkg::AM_IX0 |=> o_res.ea == {8'h00, $past(i_idx)})
        else $error("index no offset wrong");
    ix0_len_a: assert property (
        start_ok && i_ce && i_mode == cpuam_pkg::AM_IX0 |=> o_done && o_res.len == 2'h1 && !o_busy)
        else $error("index no offset length wrong");
    ix1_span_a: assert property (
        o_done && mode_q == cpuam_pkg::AM_IX1 && $past(o_busy)
        |-> o_res.ea <= 16'h01fe && o_res.ea == {8'h00, idx_q} + {8'h00, first_b})
        else $error("index 8 offset wrong");
    ix2_sum_a: assert property (
        o_done && mode_q == cpuam_pkg::AM_IX2 && $past(o_busy)
        |-> o_res.ea - {8'h00, idx_q} == {first_b, $past(i_byte)})
        else $error("index 16 offset wrong");
    rel_branch_a: assert property (
        o_done && o_res.taken |-> mode_q == cpuam_pkg::AM_REL && !bad_q)
        else $error("relative outside branch");
    bad_untaken_a: assert property (
        o_done && o_res.bad_type |-> !o_res.taken)
        else $error("flagged branch taken");
    rel_take_a: assert property (
        o_done && o_res.taken |-> o_res.next_pc == pc_q + 16'h0002 + {{8{first_b[7]}}, first_b})
        else $error("branch target wrong");
    rel_target_a: assert property (
        o_done && mode_q == cpuam_pkg::AM_REL && $past(o_busy)
        |-> o_res.ea == pc_q + 16'h0002 + {{8{first_b[7]}}, first_b})
        else $error("branch target address wrong");
    rel_skip_a: assert property (
        o_done && mode_q == cpuam_pkg::AM_REL && $past(o_busy) && !cond_q |-> o_res.next_pc == pc_q + 16'h0002)
        else $error("untaken branch moved");
    done_pulse_a: assert property (
        o_done && i_ce |=> !o_done || $past(start_ok))
        else $error("done not a pulse");
    ce_freeze_a: assert property (
        !i_ce |=> $stable(o_res) && $stable(o_done) && $stable(o_busy) && $stable(o_mul_done)
        && $stable(o_mul_hi) && $stable(o_mul_lo))
        else $error("state moved while disabled");

    ext_cov: cover property (o_done && o_res.len == 2'h3);
    bad_cov: cover property (o_done && o_res.bad_type);
    taken_cov: cover property (o_done && o_res.taken);
    mul_cov: cover property (o_mul_done && o_mul_hi != 8'h00);
    stall_cov: cover property (o_need_byte && !i_byte_valid ##1 o_need_byte && i_byte_valid);

endmodule

// ==== dv/cpuam_mem_model.sv ====
`timescale 1ns/100ps
// ****************************************
// program memory side: hands operand bytes on demand
// ****************************************
module cpuam_mem_model (
    input wire logic i_mclk,
    input wire logic i_rst_b,
    input wire logic i_need,
    input wire logic i_two,
    input wire logic i_slow,
    input wire logic [15:0] i_word,
    output logic o_valid,
    output logic [7:0] o_byte
);
    logic [1:0] cnt;
    logic stall;
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cnt <= 2'h0;
        end else if (!i_need) begin
            cnt <= 2'h0;
        end else if (o_valid) begin
            cnt <= cnt + 2'h1;
        end
    end
    always_ff @(negedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_valid <= 1'b0;
            o_byte <= 8'h5a;
            stall <= 1'b0;
        end else begin
            stall <= ~stall;
            if (i_need && !(i_slow && stall)) begin
                o_valid <= 1'b1;
                o_byte <= (i_two && cnt == 2'h0) ? i_word[15:8] : i_word[7:0];
            end else begin
                // idle bus keeps changing so stale data is never mistaken for an operand
                o_valid <= 1'b0;
                o_byte <= ~o_byte;
            end
        end
    end
endmodule

// ==== dv/cpuam_unit_tb_top.sv ====
`timescale 1ns/100ps
module cpuam_unit_tb_top;
    logic i_mclk = 1'b0;
    logic i_rst_b = 1'b0;
    logic i_start = 1'b0;
    logic [5:0] i_type = 6'h00;
    cpuam_pkg::cpuam_mode_t i_mode = cpuam_pkg::AM_INH;
    logic i_is_branch = 1'b0;
    logic i_cond = 1'b0;
    logic [15:0] i_opc_pc = 16'h0000;
    logic [7:0] i_idx = 8'h00;
    logic [7:0] i_acc = 8'h00;
    logic i_mul = 1'b0;
    logic i_ce = 1'b1;
    logic i_byte_valid;
    logic [7:0] i_byte;
    logic o_busy, o_need_byte, o_done, o_mul_done;
    logic [7:0] o_mul_hi, o_mul_lo;
    cpuam_pkg::cpuam_res_t o_res, res;
    logic two = 1'b0;
    logic slow = 1'b0;
    logic [15:0] word = 16'h0000;
    int error_cnt = 0;
    int comparisons = 0;
    int ncyc;
    always #20 i_mclk = ~i_mclk;
    cpuam_unit dut (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_ce(i_ce), .i_start(i_start), .i_type(i_type),
        .i_mode(i_mode), .i_is_branch(i_is_branch), .i_cond(i_cond), .i_opc_pc(i_opc_pc), .i_idx(i_idx),
        .i_acc(i_acc), .i_byte_valid(i_byte_valid), .i_byte(i_byte), .i_mul(i_mul), .o_busy(o_busy),
        .o_need_byte(o_need_byte), .o_done(o_done), .o_res(o_res), .o_mul_done(o_mul_done),
        .o_mul_hi(o_mul_hi), .o_mul_lo(o_mul_lo));
    cpuam_mem_model mem (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_need(o_need_byte), .i_two(two),
        .i_slow(slow), .i_word(word), .o_valid(i_byte_valid), .o_byte(i_byte));
    // ****************************************
    // shared helpers
    // ****************************************
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic decode(input cpuam_pkg::cpuam_mode_t m, input logic [5:0] t, input logic br,
        input logic c, input logic [15:0] pc, input logic [7:0] x, input logic [15:0] w, input logic s);
        logic multi;
        @(negedge i_mclk);
        i_start = 1'b1;
        i_mode = m;
        i_type = t;
        i_is_branch = br;
        i_cond = c;
        i_opc_pc = pc;
        i_idx = x;
        word = w;
        slow = s;
        two = (m == cpuam_pkg::AM_EXT || m == cpuam_pkg::AM_IX2);
        multi = (m != cpuam_pkg::AM_INH && m != cpuam_pkg::AM_IX0);
        @(negedge i_mclk);
        i_start = 1'b0;
        chk("busy", {15'h0000, multi}, {15'h0000, o_busy});
        chk("need_byte", {15'h0000, multi}, {15'h0000, o_need_byte});
        ncyc = 1;
        while (o_done !== 1'b1 && ncyc < 20) begin
            @(negedge i_mclk);
            ncyc++;
        end
        res = o_res;
        chk("done", 16'h0001, {15'h0000, o_done});
    endtask
    // n of zero skips the latency check for stalled fetches
    task automatic chk_res(input logic [15:0] ea, input logic [15:0] npc, input logic [1:0] len,
        input logic tk, input logic bad, input int n);
        chk("ea", ea, res.ea);
        chk("next_pc", npc, res.next_pc);
        chk("len", {14'h0000, len}, {14'h0000, res.len});
        chk("taken", {15'h0000, tk}, {15'h0000, res.taken});
        chk("bad_type", {15'h0000, bad}, {15'h0000, res.bad_type});
        if (n != 0) chk("cycles", n[15:0], ncyc[15:0]);
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset;
        chk("busy", 16'h0000, {15'h0000, o_busy});
        chk("res_lo", cpuam_pkg::RST_RES[15:0], o_res[15:0]);
        chk("res_hi", cpuam_pkg::RST_RES[43:28], o_res[43:28]);
        $display("test reset done");
    endtask
    task automatic t_types;
        for (int t = 0; t < 64; t++) begin
            decode(cpuam_pkg::AM_INH, t[5:0], 1'b0, 1'b0, 16'h0100, 8'h00, 16'h0000, 1'b0);
            chk("bad_type", {15'h0000, t >= 62}, {15'h0000, res.bad_type});
        end
        $display("test types done");
    endtask
    task automatic t_modes;
        decode(cpuam_pkg::AM_INH, 6'h01, 1'b0, 1'b0, 16'hffff, 8'h33, 16'h0000, 1'b0);
        chk("next_pc", 16'h0000, res.next_pc);
        chk("len", 16'h0001, {14'h0000, res.len});
        chk("cycles", 16'h0001, ncyc[15:0]);
        decode(cpuam_pkg::AM_IMM, 6'h02, 1'b0, 1'b0, 16'h0200, 8'h00, 16'h00a5, 1'b0);
        chk_res(16'h0000, 16'h0202, 2'h2, 1'b0, 1'b0, 2);
        chk("literal", 16'h00a5, {8'h00, res.literal});
        decode(cpuam_pkg::AM_DIR, 6'h03, 1'b0, 1'b0, 16'h0300, 8'h00, 16'h77ff, 1'b0);
        chk_res(16'h00ff, 16'h0302, 2'h2, 1'b0, 1'b0, 2);
        decode(cpuam_pkg::AM_EXT, 6'h04, 1'b0, 1'b0, 16'h0400, 8'h00, 16'habcd, 1'b1);
        chk_res(16'habcd, 16'h0403, 2'h3, 1'b0, 1'b0, 0);
        decode(cpuam_pkg::AM_IX0, 6'h05, 1'b0, 1'b0, 16'h0500, 8'hff, 16'h0000, 1'b0);
        chk_res(16'h00ff, 16'h0501, 2'h1, 1'b0, 1'b0, 1);
        decode(cpuam_pkg::AM_IX1, 6'h06, 1'b0, 1'b0, 16'h0600, 8'hff, 16'h00ff, 1'b0);
        chk_res(16'h01fe, 16'h0602, 2'h2, 1'b0, 1'b0, 2);
        decode(cpuam_pkg::AM_IX2, 6'h07, 1'b0, 1'b0, 16'h0700, 8'h20, 16'h12f0, 1'b0);
        chk_res(16'h1310, 16'h0703, 2'h3, 1'b0, 1'b0, 3);
        $display("test modes done");
    endtask
    task automatic t_branch;
        decode(cpuam_pkg::AM_REL, 6'h08, 1'b1, 1'b1, 16'h1000, 8'h00, 16'h0080, 1'b0);
        chk_res(16'h0f82, 16'h0f82, 2'h2, 1'b1, 1'b0, 2);
        decode(cpuam_pkg::AM_REL, 6'h09, 1'b1, 1'b1, 16'h1000, 8'h00, 16'h007f, 1'b1);
        chk_res(16'h1081, 16'h1081, 2'h2, 1'b1, 1'b0, 0);
        decode(cpuam_pkg::AM_REL, 6'h0a, 1'b1, 1'b0, 16'h1000, 8'h00, 16'h007f, 1'b0);
        chk_res(16'h1081, 16'h1002, 2'h2, 1'b0, 1'b0, 2);
        decode(cpuam_pkg::AM_REL, 6'h0b, 1'b0, 1'b1, 16'h1000, 8'h00, 16'h0010, 1'b0);
        chk("bad_type", 16'h0001, {15'h0000, res.bad_type});
        chk("taken", 16'h0000, {15'h0000, res.taken});
        $display("test branch done");
    endtask
    task automatic t_mul;
        logic [15:0] ops [3];
        ops = '{16'hffff, 16'h00ff, 16'h1234};
        for (int k = 0; k < 3; k++) begin
            @(negedge i_mclk);
            i_mul = 1'b1;
            i_acc = ops[k][15:8];
            i_idx = ops[k][7:0];
            @(negedge i_mclk);
            i_mul = 1'b0;
            chk("mul_done", 16'h0001, {15'h0000, o_mul_done});
            chk("product", {8'h00, ops[k][15:8]} * {8'h00, ops[k][7:0]}, {o_mul_hi, o_mul_lo});
        end
        @(negedge i_mclk);
        chk("mul_done", 16'h0000, {15'h0000, o_mul_done});
        $display("test multiply done");
    endtask
    // clock enable low must hold the last product and defer the request until enable returns
    task automatic t_freeze;
        @(negedge i_mclk);
        i_ce = 1'b0;
        i_mul = 1'b1;
        i_acc = 8'hff;
        i_idx = 8'h02;
        @(negedge i_mclk);
        chk("mul_done", 16'h0000, {15'h0000, o_mul_done});
        chk("product", 16'h03a8, {o_mul_hi, o_mul_lo});
        i_ce = 1'b1;
        @(negedge i_mclk);
        i_mul = 1'b0;
        chk("mul_done", 16'h0001, {15'h0000, o_mul_done});
        chk("product", 16'h01fe, {o_mul_hi, o_mul_lo});
        $display("test freeze done");
    endtask
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(negedge i_mclk);
        i_rst_b = 1'b1;
        t_reset();
        t_types();
        t_modes();
        t_branch();
        t_mul();
        t_freeze();
        close_out();
    end
    // the whole run needs well under a thousand cycles
    initial begin
        #80000;
        error_cnt++;
        close_out();
    end
endmodule
